// ---- rtl/mcs_cfg.svh ----
`ifndef MCS_CFG_SVH
`define MCS_CFG_SVH
// register byte addresses (printed offsets are indices, address = 4 * index)
`define MCS_IDX_SET 8'h08
`define MCS_IDX_CLR 8'h09
`define MCS_IDX_MODE0 8'h0A
`define MCS_IDX_STATUS 8'h0B
`define MCS_IDX_EVENT 8'h0C
`define MCS_ADDR_SET 12'h020
`define MCS_ADDR_CLR 12'h024
`define MCS_ADDR_MODE0 12'h028
`define MCS_ADDR_STATUS 12'h02C
`define MCS_ADDR_EVENT 12'h030
// mode register 1 bit positions
`define MCS_B_LEAVE_OFF 0
`define MCS_B_EOI 1
`define MCS_B_GO_OFF 2
`define MCS_B_DROP 3
`define MCS_B_SWAP_EN 4
`define MCS_B_WD_RELOAD 5
// mode register 0 bit positions
`define MCS_B_INT_TB 9
`define MCS_B_WATCHDOG_TEST_SELECT 11
`define MCS_B_SPEC_PRM 12
`define MCS_MODE0_MASK 16'h1FFF
`define MCS_MODE0_RST 16'h0000
`define MCS_MODE1_RST 8'h00
// interrupt inactive times
`define MCS_CLK_NS 10
`define MCS_T_SHORT_US 1
`define MCS_T_LONG_MS 1
`define MCS_CYC_SHORT ((`MCS_T_SHORT_US * 1000) / `MCS_CLK_NS)
`define MCS_CYC_LONG ((`MCS_T_LONG_MS * 1000000) / `MCS_CLK_NS)
`define MCS_CNT_W 17
`endif

// ---- rtl/mcs_pkg.sv ----
package mcs_pkg;
    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } mcs_apb_req_s;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } mcs_apb_rsp_s;
    typedef enum logic [1:0] {
        MCS_OFFLINE = 2'b00,
        MCS_IDLE = 2'b01,
        MCS_DRAIN = 2'b11
    } mcs_run_e;
endpackage

// ---- rtl/mcs_int_gap.sv ----
`timescale 1ns/1ps
`include "mcs_cfg.svh"
// holds the interrupt output inactive for the chosen time after an end of interrupt
module mcs_int_gap
    import mcs_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic long_in,
    output logic busy_out
);
    localparam logic [`MCS_CNT_W-1:0] SHORT_C = `MCS_CNT_W'(`MCS_CYC_SHORT);
    localparam logic [`MCS_CNT_W-1:0] LONG_C = `MCS_CNT_W'(`MCS_CYC_LONG);
    logic [`MCS_CNT_W-1:0] cnt_r;
    logic [`MCS_CNT_W-1:0] cnt_nxt;
    logic busy_r;
    // load on start, count down to zero
    assign cnt_nxt = start_in ? (long_in ? LONG_C : SHORT_C) :
                     (cnt_r != '0) ? cnt_r - `MCS_CNT_W'(1) : cnt_r;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= (cnt_nxt != '0);
        end
    end
    assign busy_out = busy_r;
endmodule // mcs_int_gap

// ---- rtl/mcs_mode_ctrl.sv ----
`timescale 1ns/1ps
`include "mcs_cfg.svh"
module mcs_mode_ctrl
    import mcs_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire mcs_apb_req_s apb_in,
    output mcs_apb_rsp_s apb_out,
    input wire logic req_busy_in,
    input wire logic int_req_in,
    input wire logic cfg_accept_in,
    output logic int_out,
    output logic timers_start_out,
    output logic drop_master_out,
    output logic wd_reload_out,
    output logic cfg_swap_out,
    output logic spec_prm_mode_out,
    output logic [15:0] mode0_out
);
    logic [15:0] mode0_r;
    logic [7:0] mode1_r;
    logic [7:0] mode1_nxt;
    mcs_run_e run_r;
    mcs_run_e run_nxt;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic int_r;
    logic timers_start_r;
    logic drop_r;
    logic reload_r;
    logic swap_r;
    logic [3:0] events_r;
    logic gap_busy;

    // apb decode: one-wait-state slave, answer in the second cycle of the access phase
    wire acc = apb_in.psel & apb_in.penable & ~pready_r;
    wire wr = acc & apb_in.pwrite;
    wire rd = acc & ~apb_in.pwrite;
    wire hit_set = apb_in.paddr == `MCS_ADDR_SET;
    wire hit_clr = apb_in.paddr == `MCS_ADDR_CLR;
    wire hit_m0 = apb_in.paddr == `MCS_ADDR_MODE0;
    wire hit_st = apb_in.paddr == `MCS_ADDR_STATUS;
    wire hit_ev = apb_in.paddr == `MCS_ADDR_EVENT;
    wire mapped = hit_set | hit_clr | hit_m0 | hit_st | hit_ev;
    wire [7:0] set_mask = (wr & hit_set) ? apb_in.pwdata[7:0] & 8'h3F : 8'h00;
    wire [7:0] clr_mask = (wr & hit_clr) ? apb_in.pwdata[7:0] & 8'h3F : 8'h00;
    wire offline = run_r == MCS_OFFLINE;
    wire m0_wr = wr & hit_m0 & offline; // writes outside offline ignored

    // command bits as stored
    wire leave_cmd = mode1_r[`MCS_B_LEAVE_OFF];
    wire eoi_cmd = mode1_r[`MCS_B_EOI];
    wire go_off_cmd = mode1_r[`MCS_B_GO_OFF];
    wire drop_cmd = mode1_r[`MCS_B_DROP];
    wire swap_en = mode1_r[`MCS_B_SWAP_EN];
    wire reload_cmd = mode1_r[`MCS_B_WD_RELOAD];

    // run state: offline, passive idle, draining before offline
    always_comb begin
        run_nxt = run_r;
        case (run_r)
            MCS_OFFLINE: begin
                if (leave_cmd) begin
                    run_nxt = MCS_IDLE;
                end
            end
            MCS_IDLE: begin
                if (go_off_cmd) begin
                    run_nxt = MCS_DRAIN;
                end
            end
            MCS_DRAIN: begin
                if (!req_busy_in) begin
                    run_nxt = MCS_OFFLINE; // current request finished
                end
            end
            default: run_nxt = MCS_OFFLINE;
        endcase
    end

    // self-clearing commands: host set wins over hardware clear
    always_comb begin
        mode1_nxt = (mode1_r & ~clr_mask) | set_mask;
        if (leave_cmd) begin
            mode1_nxt[`MCS_B_LEAVE_OFF] = set_mask[`MCS_B_LEAVE_OFF];
            mode1_nxt[`MCS_B_GO_OFF] = set_mask[`MCS_B_GO_OFF];
        end
        if (eoi_cmd) begin
            mode1_nxt[`MCS_B_EOI] = set_mask[`MCS_B_EOI];
        end
        if (go_off_cmd && run_r == MCS_DRAIN && !req_busy_in) begin
            mode1_nxt[`MCS_B_GO_OFF] = set_mask[`MCS_B_GO_OFF];
        end
        if (go_off_cmd && offline && !leave_cmd) begin
            mode1_nxt[`MCS_B_GO_OFF] = set_mask[`MCS_B_GO_OFF]; // already offline
        end
        if (drop_cmd) begin
            mode1_nxt[`MCS_B_DROP] = set_mask[`MCS_B_DROP];
        end
        if (reload_cmd) begin
            mode1_nxt[`MCS_B_WD_RELOAD] = set_mask[`MCS_B_WD_RELOAD];
        end
    end

    // interrupt inactive time after end of interrupt
    mcs_int_gap u_gap (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .start_in(eoi_cmd),
        .long_in(mode0_r[`MCS_B_INT_TB]),
        .busy_out(gap_busy)
    );

    // read data selection
    wire [31:0] rd_data =
        hit_m0 ? {16'h0000, mode0_r} :
        hit_st ? {29'h00000000, run_r == MCS_DRAIN, mode1_r[`MCS_B_SWAP_EN], ~offline} :
        hit_ev ? {28'h0000000, events_r} :
        32'h00000000;

    // registers and bus answer
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mode0_r <= `MCS_MODE0_RST;
            mode1_r <= `MCS_MODE1_RST;
            run_r <= MCS_OFFLINE;
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            if (m0_wr) begin
                mode0_r <= apb_in.pwdata[15:0] & `MCS_MODE0_MASK;
            end
            mode1_r <= mode1_nxt;
            run_r <= run_nxt;
            pready_r <= acc;
            pslverr_r <= acc & ~mapped;
            prdata_r <= rd ? rd_data : 32'h00000000;
        end
    end

    // command outputs as one-cycle pulses, interrupt output as a level that follows int_req_in, held low during eoi and its inactive gap
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            int_r <= 1'b0;
            timers_start_r <= 1'b0;
            drop_r <= 1'b0;
            reload_r <= 1'b0;
            swap_r <= 1'b0;
            events_r <= 4'h0;
        end else begin
            int_r <= int_req_in & ~eoi_cmd & ~gap_busy;
            timers_start_r <= leave_cmd & offline;
            drop_r <= drop_cmd;
            reload_r <= reload_cmd;
            swap_r <= cfg_accept_in & swap_en;
            events_r <= {reload_cmd, drop_cmd, leave_cmd & offline, eoi_cmd} |
                        (events_r & ~((wr & hit_ev) ? apb_in.pwdata[3:0] : 4'h0));
        end
    end

    assign apb_out = '{prdata: prdata_r, pready: pready_r, pslverr: pslverr_r};
    assign int_out = int_r;
    assign timers_start_out = timers_start_r;
    assign drop_master_out = drop_r;
    assign wd_reload_out = reload_r;
    assign cfg_swap_out = swap_r;
    assign spec_prm_mode_out = mode0_r[`MCS_B_SPEC_PRM];
    assign mode0_out = mode0_r;

    // checks
    eoi_clears_a: assert property (@(posedge clk_in) disable iff (rst_in)
        eoi_cmd && !set_mask[`MCS_B_EOI] |=> !eoi_cmd) else $error("eoi not cleared");
    int_quiet_a: assert property (@(posedge clk_in) disable iff (rst_in)
        eoi_cmd |=> !int_out [*8]) else $error("interrupt active too soon");
    leave_idle_a: assert property (@(posedge clk_in) disable iff (rst_in)
        leave_cmd && offline |=> run_r == MCS_IDLE && timers_start_out) else $error("no start");
    leave_goff_a: assert property (@(posedge clk_in) disable iff (rst_in)
        leave_cmd && !set_mask[`MCS_B_GO_OFF] |=> !go_off_cmd) else $error("go off kept");
    sequence drain_done_s;
        run_r == MCS_DRAIN && !req_busy_in;
    endsequence
    drain_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
        drain_done_s |=> offline) else $error("not offline after drain");
    drain_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        run_r == MCS_DRAIN && req_busy_in |=> run_r == MCS_DRAIN) else $error("left early");
    set_bit_a: assert property (@(posedge clk_in) disable iff (rst_in)
        set_mask[`MCS_B_SWAP_EN] && !clr_mask[`MCS_B_SWAP_EN] |=> swap_en) else $error("set");
    clr_bit_a: assert property (@(posedge clk_in) disable iff (rst_in)
        clr_mask[`MCS_B_SWAP_EN] && !set_mask[`MCS_B_SWAP_EN] |=> !swap_en) else $error("clr");
    zero_keep_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !set_mask[`MCS_B_SWAP_EN] && !clr_mask[`MCS_B_SWAP_EN] |=> $stable(swap_en))
        else $error("swap bit changed");
    swap_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
        cfg_accept_in && !swap_en |=> !cfg_swap_out) else $error("swap not allowed");
    swap_do_a: assert property (@(posedge clk_in) disable iff (rst_in)
        cfg_accept_in && swap_en |=> cfg_swap_out) else $error("swap missed");
    drop_pulse_a: assert property (@(posedge clk_in) disable iff (rst_in)
        drop_cmd |=> drop_master_out) else $error("drop missed");
    reload_pulse_a: assert property (@(posedge clk_in) disable iff (rst_in)
        reload_cmd |=> wd_reload_out) else $error("reload missed");
    mode0_lock_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !offline |=> $stable(mode0_r)) else $error("mode0 changed online");

    // self-clear of the one-shot commands when the host does not set them again, and idle to drain on go offline
    sequence drop_once_s;
        drop_cmd && !set_mask[`MCS_B_DROP];
    endsequence
    sequence reload_once_s;
        reload_cmd && !set_mask[`MCS_B_WD_RELOAD];
    endsequence
    drop_clears_a: assert property (@(posedge clk_in) disable iff (rst_in)
        drop_once_s |=> !drop_cmd) else $error("drop not cleared");
    reload_clears_a: assert property (@(posedge clk_in) disable iff (rst_in)
        reload_once_s |=> !reload_cmd) else $error("reload not cleared");
    goff_clears_a: assert property (@(posedge clk_in) disable iff (rst_in)
        drain_done_s ##0 !set_mask[`MCS_B_GO_OFF] |=> !go_off_cmd)
        else $error("go off not cleared");
    idle_drain_a: assert property (@(posedge clk_in) disable iff (rst_in)
        run_r == MCS_IDLE && go_off_cmd |=> run_r == MCS_DRAIN)
        else $error("no drain");

    // swap enable is a plain level, not a one-shot
    swap_level_a: assert property (@(posedge clk_in) disable iff (rst_in)
        swap_en && !clr_mask[`MCS_B_SWAP_EN] |=> swap_en) else $error("swap bit lost");

    // unused mode register 1 bits never set
    top_bits_a: assert property (@(posedge clk_in) disable iff (rst_in)
        mode1_r[7:6] == 2'b00) else $error("bits 6 7 set");

    // interrupt held low while the inactive gap runs
    gap_quiet_a: assert property (@(posedge clk_in) disable iff (rst_in)
        gap_busy |=> !int_out) else $error("interrupt during gap");

    // timer start only ever comes out of offline
    start_src_a: assert property (@(posedge clk_in) disable iff (rst_in)
        timers_start_out |-> $past(offline)) else $error("start while online");

    // special buffer mode output follows its stored bit
    spec_out_a: assert property (@(posedge clk_in) disable iff (rst_in)
        spec_prm_mode_out == mode0_r[`MCS_B_SPEC_PRM]) else $error("spec mode wrong");

    // mode register 0 upper bits stay zero
    mode0_top_a: assert property (@(posedge clk_in) disable iff (rst_in)
        mode0_r[15:13] == 3'b000) else $error("mode0 top bits set");

    // status bit 0 reads passive idle outside offline
    status_idle_a: assert property (@(posedge clk_in) disable iff (rst_in)
        rd && hit_st |=> apb_out.prdata[0] == $past(~offline))
        else $error("status bit 0 wrong");

    // bus answer is a single-cycle pulse, error only with it
    ready_pulse_a: assert property (@(posedge clk_in) disable iff (rst_in)
        pready_r |=> !pready_r) else $error("ready held");
    err_ready_a: assert property (@(posedge clk_in) disable iff (rst_in)
        pslverr_r |-> pready_r) else $error("error without ready");
endmodule // mcs_mode_ctrl

// ---- sim/mcs_host_model.sv ----
`timescale 1ns/1ps
`include "mcs_cfg.svh"
// host processor on the register bus: one transfer at a time
module mcs_host_model
    import mcs_pkg::*;
(
    input wire logic clk_in,
    input wire mcs_apb_rsp_s apb_in,
    output mcs_apb_req_s apb_out
);
    int n_timeout = 0;
    initial apb_out = '0;
    // setup, then access held until pready is seen high at a rising edge
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] rdat, output logic err);
        int n;
        n = 0;
        @(posedge clk_in);
        apb_out <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge clk_in);
        apb_out.penable <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (apb_in.pready !== 1'b1 && n < 50);
        if (apb_in.pready !== 1'b1) begin
            n_timeout++; // no answer within the limit
        end
        rdat = apb_in.prdata;
        err = apb_in.pslverr;
        // released lines show the inverse, never the old value
        apb_out <= '{paddr: ~a, psel: 1'b0, penable: 1'b0, pwrite: ~w, pwdata: ~d};
    endtask
    // mode0 write: watchdog test forced to 0, caller only uses it offline
    task automatic wr_mode0(input logic [31:0] d, output logic [31:0] sent);
        logic [31:0] r;
        logic e;
        sent = d & ~(32'h1 << `MCS_B_WATCHDOG_TEST_SELECT);
        xfer(`MCS_ADDR_MODE0, 1'b1, sent, r, e);
    endtask
endmodule // mcs_host_model

// ---- sim/mode_control_set_clear_tb.sv ----
`timescale 1ns/1ps
`include "mcs_cfg.svh"
module mode_control_set_clear_tb
    import mcs_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_busy_in = 1'b0;
    logic int_req_in = 1'b0;
    logic cfg_accept_in = 1'b0;
    mcs_apb_req_s apb_req;
    mcs_apb_rsp_s apb_rsp;
    logic int_out, t_start, drop, reload, swap, spec;
    logic [15:0] mode0_out;
    logic [31:0] rdat, d, seed = 32'h4364CB79;
    logic err;
    int n_mismatch = 0, checked = 0, n_st = 0, n_dr = 0, n_rl = 0, n_sw = 0, n;
    always #5 clk_in = ~clk_in;
    mcs_host_model u_host (.clk_in(clk_in), .apb_in(apb_rsp), .apb_out(apb_req));
    mcs_mode_ctrl uut (.clk_in(clk_in), .rst_in(rst_in), .apb_in(apb_req), .apb_out(apb_rsp),
        .req_busy_in(req_busy_in), .int_req_in(int_req_in), .cfg_accept_in(cfg_accept_in),
        .int_out(int_out), .timers_start_out(t_start), .drop_master_out(drop),
        .wd_reload_out(reload), .cfg_swap_out(swap), .spec_prm_mode_out(spec),
        .mode0_out(mode0_out));
    // count the cycles each command pulse is high
    always @(posedge clk_in) begin
        n_st += t_start;
        n_dr += drop;
        n_rl += reload;
        n_sw += swap;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        u_host.xfer(a, 1'b1, v, rdat, err);
    endtask
    task automatic rd(input logic [11:0] a);
        u_host.xfer(a, 1'b0, 32'h0, rdat, err);
    endtask
    task automatic accept;
        cfg_accept_in <= 1'b1;
        @(posedge clk_in);
        cfg_accept_in <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // cut a hang short
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        check({int_out, t_start, drop, reload, swap, spec, mode0_out}, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 2; i++) begin
            seed = xs(seed);
            d = seed & ~(32'h1 << `MCS_B_INT_TB);
            d[`MCS_B_SPEC_PRM] = i[0];
            u_host.wr_mode0(d, d);
            check(mode0_out, d & `MCS_MODE0_MASK);
            check(spec, i[0]);
        end
        $display("test mode0 done");
        wr(`MCS_ADDR_SET, 32'h1);
        rd(`MCS_ADDR_STATUS);
        check(rdat[0], 1'b1);
        check(n_st, 1);
        wr(`MCS_ADDR_SET, (xs(seed) & 32'hFFFFFF00) | 32'hC0);
        rd(`MCS_ADDR_STATUS);
        check({n_st, rdat[2:0]}, {32'd1, 3'b001});
        $display("test leave offline done");
        accept();
        check(n_sw, 0);
        wr(`MCS_ADDR_SET, 32'h10);
        accept();
        check(n_sw, 1);
        wr(`MCS_ADDR_CLR, 32'h10);
        rd(`MCS_ADDR_STATUS);
        check(rdat[1:0], 2'b01);
        accept();
        check(n_sw, 1);
        $display("test swap done");
        wr(`MCS_ADDR_SET, 32'h28);
        repeat (3) @(posedge clk_in);
        check(n_dr, 1);
        check(n_rl, 1);
        rd(`MCS_ADDR_EVENT);
        check(rdat, 32'h0000000E);
        wr(`MCS_ADDR_EVENT, 32'hF);
        rd(`MCS_ADDR_EVENT);
        check(rdat, 32'h00000000);
        $display("test drop reload done");
        int_req_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        check(int_out, 1'b1);
        wr(`MCS_ADDR_SET, 32'h2);
        @(posedge clk_in);
        n = 0;
        while (int_out !== 1'b1 && n < 300) begin
            @(posedge clk_in);
            n++;
        end
        check(n >= `MCS_CYC_SHORT - 2 && n <= `MCS_CYC_SHORT + 4, 1'b1);
        check(int_out, 1'b1);
        $display("test eoi done");
        req_busy_in <= 1'b1;
        wr(`MCS_ADDR_SET, 32'h4);
        rd(`MCS_ADDR_STATUS);
        check(rdat[2:0], 3'b101);
        req_busy_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        rd(`MCS_ADDR_STATUS);
        check(rdat[2:0], 3'b000);
        rd(12'h0FC);
        check({err, rdat[30:0]}, 32'h80000000);
        $display("test offline done");
        check(u_host.n_timeout, 0);
        give_verdict();
    end
endmodule // mode_control_set_clear_tb
